/* File: hw/rmc_link_if.sv */
// Serial command and reply link between sequencer and rod hydraulic unit.
`timescale 1ns/10ps
interface rmc_link_if;
  logic cmd_bit;
  logic cmd_frame;
  logic rep_bit;
  logic rep_frame;
  modport seq (output cmd_bit, output cmd_frame,
               input rep_bit, input rep_frame);
  modport unit (input cmd_bit, input cmd_frame,
                output rep_bit, output rep_frame);
endinterface : rmc_link_if

/* File: hw/rmc_pkg.sv */
// Shared constants, encodings and helpers of the rod motion command link.
package rmc_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WORD_US = 100;
  localparam int WORD_CYC = WORD_US * (CLK_HZ / 1_000_000);
  // One command slot plus one scan or test slot make up the fast loop.
  localparam int FAST_LOOP_US = 200;
  localparam int MED_LOOP_MS = 143;
  localparam int MED_LOOP_CYC = MED_LOOP_MS * (CLK_HZ / 1000);
  // The slow loop is ROD_COUNT medium loops, one unit tested per loop.
  localparam int SLOW_LOOP_MIN_S = 40;
  localparam int SLOW_LOOP_MAX_S = 240;
  localparam int REPLY_TO_CYC = 64;
  localparam int HOLD_WORDS = 3;
  localparam int HOLD_CYC = HOLD_WORDS * WORD_CYC;
  localparam int TEST_PULSE_CYC = 4;
  localparam int MOVE_SLOTS = 4;
  localparam int SETTLE_SLOTS = 2;
  localparam int MISS_LIMIT = 3;

  // ==========================================================================
  // Word layout
  localparam int ADDR_W = 9;
  localparam int OP_W = 4;
  localparam int CMD_W = ADDR_W + OP_W;
  localparam int STAT_W = 8;
  localparam int REP_W = CMD_W + STAT_W;
  localparam int ROD_COUNT = 280;
  localparam int TEST_STEPS = 14;

  localparam logic [3:0] OP_STATUS = 4'h0;
  localparam logic [3:0] OP_INSERT = 4'h1;
  localparam logic [3:0] OP_WITHDRAW = 4'h2;
  localparam logic [3:0] OP_SETTLE = 4'h3;
  localparam logic [3:0] OP_TEST = 4'h8;
  localparam int OP_TEST_BIT = 3;

  // Valve bits: 0 insert supply, 1 insert exhaust, 2 withdraw, 3 settle.
  localparam logic [3:0] VLV_CLOSED = 4'h0;
  localparam logic [3:0] VLV_INSERT = 4'h3;
  localparam logic [3:0] VLV_WITHDRAW = 4'hC;
  localparam logic [3:0] VLV_SETTLE = 4'h8;

  // Pushbutton positions on the panel input vector.
  localparam int BTN_INS = 0;
  localparam int BTN_WD = 1;
  localparam int BTN_CINS = 2;
  localparam int BTN_CWD = 3;

  // ==========================================================================
  // Register map
  localparam logic [3:0] REG_SELECT = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_REPLY = 4'hC;
  localparam int SEL_VALID_BIT = 9;
  localparam int CTL_CLEAR_BIT = 0;
  localparam int ST_FAULT = 0;
  localparam int ST_CMP_FAIL = 1;
  localparam int ST_MOVING = 2;
  localparam int ST_SELECTED = 3;
  localparam int ST_MV_LSB = 4;
  localparam int ST_MISS_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PH_IDLE, PH_CMP, PH_SEND, PH_WAIT} rmc_phase_t;
  typedef enum logic [1:0] {MV_IDLE, MV_INS, MV_WD, MV_SET} rmc_move_t;

  function automatic logic [CMD_W-1:0] rmc_build_cmd(
    input logic [ADDR_W-1:0] addr,
    input logic [OP_W-1:0] op
  );
    rmc_build_cmd = {addr, op};
  endfunction : rmc_build_cmd

  function automatic logic [3:0] rmc_valves(input logic [1:0] mv);
    case (mv)
      2'h1: rmc_valves = VLV_INSERT;
      2'h2: rmc_valves = VLV_WITHDRAW;
      2'h3: rmc_valves = VLV_SETTLE;
      default: rmc_valves = VLV_CLOSED;
    endcase
  endfunction : rmc_valves

endpackage : rmc_pkg

/* File: hw/rmc_rod_unit.sv */
// Rod hydraulic unit end: decodes addressed commands and replies.
`timescale 1ns/10ps
module rmc_rod_unit
  import rmc_pkg::*;
#(
  parameter int HOLD_CYC_P = HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] unit_addr_i,
  input wire logic accum_ok_i,
  input wire logic [2:0] test_sw_i,
  output logic [3:0] valves_o,
  rmc_link_if.unit link
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] stat;
    logic [CMD_W-1:0] rx;
    logic [5:0] rx_cnt;
    logic [REP_W-1:0] tx;
    logic [5:0] tx_cnt;
    logic rep_bit;
    logic rep_frame;
    logic [3:0] valves;
    logic [15:0] hold_cnt;
    logic [3:0] test_cnt;
  } rmc_unit_state_t;

  rmc_unit_state_t q;
  rmc_unit_state_t d;

  // ==========================================================================
  // Next state
  always_comb begin
    logic [OP_W-1:0] op;
    op = q.rx[OP_W-1:0];
    d = q;
    d.s1 = {accum_ok_i, test_sw_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.stat = q.s3;
    end

    // The drive is AC-coupled: valves close unless frames keep arriving.
    if (q.hold_cnt != 16'h0) begin
      d.hold_cnt = q.hold_cnt - 16'h1;
      if (q.hold_cnt == 16'h1) begin
        d.valves = VLV_CLOSED;
      end
    end
    // Test pulses are too short for the valves to move.
    if (q.test_cnt != 4'h0) begin
      d.test_cnt = q.test_cnt - 4'h1;
      if (q.test_cnt == 4'h1 && q.hold_cnt == 16'h0) begin
        d.valves = VLV_CLOSED;
      end
    end

    if (link.cmd_frame) begin
      d.rx = {q.rx[CMD_W-2:0], link.cmd_bit};
      if (q.rx_cnt != 6'h3F) begin
        d.rx_cnt = q.rx_cnt + 6'h1;
      end
    end else if (q.rx_cnt != 6'h0) begin
      d.rx_cnt = 6'h0;
      // Frames for other units leave this one silent.
      if (q.rx_cnt == 6'(CMD_W) &&
          q.rx[CMD_W-1 -: ADDR_W] == unit_addr_i) begin
        if (op[OP_TEST_BIT]) begin
          if (q.hold_cnt == 16'h0) begin
            d.valves = rmc_valves(op[1:0]);
            d.test_cnt = 4'(TEST_PULSE_CYC);
          end
        end else if (op != OP_STATUS) begin
          d.valves = rmc_valves(op[1:0]);
          d.hold_cnt = 16'(HOLD_CYC_P);
        end
        d.tx = {unit_addr_i, op, d.valves, d.stat};
        d.tx_cnt = 6'(REP_W);
      end
    end

    d.rep_frame = (q.tx_cnt != 6'h0);
    d.rep_bit = (q.tx_cnt != 6'h0) ? q.tx[REP_W-1] : 1'b0;
    if (q.tx_cnt != 6'h0) begin
      d.tx = {q.tx[REP_W-2:0], 1'b0};
      d.tx_cnt = q.tx_cnt - 6'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.rep_bit = q.rep_bit;
  assign link.rep_frame = q.rep_frame;
  assign valves_o = q.valves;

endmodule : rmc_rod_unit

/* File: hw/rmc_sequencer.sv */
// Rod command sequencer with redundant channels and AXI4-Lite registers.
`timescale 1ns/10ps
// ============================================================================
// Overview of operation
// - Build command twice, send only if identical
// - Broadcast serial frame: unit address, operation code
// - Only the addressed unit acts and replies
// - Reply carries address, operation and unit status
// - Insert and withdraw use distinct operation codes
// - Compare copies bit by bit, 100 us words
// - Motion needs repeating commands; silence stops valves
// - Copy disagreement withholds frame and blocks motion
// - Stop motion after preset count of reply mismatches
// - Stay stopped until operator clears the fault
// - Fast loop alternates command and scan/test slots
// - Medium 143 ms loop: scan all, test one
// - Slow loop tests every unit with short pulses
// - Selection holds until reselect or deselect
// - No other selection while rod is moving
// - No deselect while moving except power loss
// - Three modes as four-valve patterns
// - Settle follows every insert and withdraw not ended by a fault
// - Settle opens only the settle withdraw valve
// - Four spring-return pushbuttons give direction
module rmc_sequencer
  import rmc_pkg::*;
#(
  parameter int WORD_CYC_P = WORD_CYC,
  parameter int MED_CYC_P = MED_LOOP_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] btn_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic moving_o,
  output logic fault_o,
  rmc_link_if.seq link
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] btn;
    logic [3:0] btn_prev;
    logic sel_valid;
    logic [ADDR_W-1:0] sel_a;
    logic [ADDR_W-1:0] sel_b;
    rmc_move_t mv;
    logic [3:0] mv_cnt;
    logic moving;
    logic fault;
    logic cmp_fail;
    logic [3:0] miss;
    rmc_phase_t phase;
    logic [15:0] slot_cnt;
    logic [23:0] med_cnt;
    logic cmd_slot;
    logic motion_frame;
    logic [6:0] bit_cnt;
    logic [CMD_W-1:0] sh_a;
    logic [CMD_W-1:0] sh_b;
    logic [CMD_W-1:0] word_b;
    logic [REP_W-1:0] rx;
    logic [5:0] rx_cnt;
    logic [REP_W-1:0] last_rep;
    logic [ADDR_W-1:0] scan_idx;
    logic scan_done;
    logic [ADDR_W-1:0] test_unit;
    logic [3:0] test_step;
    logic cmd_bit;
    logic cmd_frame;
    logic aw_have;
    logic w_have;
    logic [3:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rmc_seq_state_t;

  rmc_seq_state_t q;
  rmc_seq_state_t d;

  // ==========================================================================
  // Next state
  always_comb begin
    logic clr;
    logic go;
    logic miss_ev;
    logic [ADDR_W-1:0] addr_a;
    logic [ADDR_W-1:0] addr_b;
    logic [OP_W-1:0] op;
    logic [31:0] selw;
    logic [31:0] rword;
    logic [1:0] rresp;
    clr = 1'b0;
    go = 1'b0;
    miss_ev = 1'b0;
    addr_a = '0;
    addr_b = '0;
    op = OP_STATUS;
    selw = 32'h0;
    rword = 32'h0;
    rresp = RESP_OKAY;
    d = q;
    d.cmd_bit = 1'b0;
    d.cmd_frame = 1'b0;

    // Panel buttons read inactive when released; a level counts once stable.
    d.s1 = btn_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.btn = q.s3;
    end
    d.btn_prev = q.btn;

    selw[ADDR_W-1:0] = q.sel_b;
    selw[SEL_VALID_BIT] = q.sel_valid;

    // ========================================================================
    // AXI4-Lite write: address and data in either order.
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata_i;
      d.wstrb = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.aw_addr)
        REG_SELECT: begin
          for (int i = 0; i < 4; i++) begin
            if (q.wstrb[i]) begin
              selw[8*i +: 8] = q.wdata[8*i +: 8];
            end
          end
          // Selection is frozen for the whole movement cycle.
          if (q.mv == MV_IDLE) begin
            d.sel_valid = selw[SEL_VALID_BIT];
            d.sel_a = selw[ADDR_W-1:0];
            d.sel_b = selw[ADDR_W-1:0];
          end
        end
        REG_CONTROL: clr = q.wstrb[0] & q.wdata[CTL_CLEAR_BIT];
        REG_STATUS, REG_REPLY: ;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    // ========================================================================
    // AXI4-Lite read.
    case (s_axi_araddr_i)
      REG_SELECT: rword = selw;
      REG_CONTROL: rword = 32'h0;
      REG_STATUS: begin
        rword[ST_FAULT] = q.fault;
        rword[ST_CMP_FAIL] = q.cmp_fail;
        rword[ST_MOVING] = q.moving;
        rword[ST_SELECTED] = q.sel_valid;
        rword[ST_MV_LSB +: 2] = q.mv;
        rword[ST_MISS_LSB +: 4] = q.miss;
      end
      REG_REPLY: rword[REP_W-1:0] = q.last_rep;
      default: rresp = RESP_SLVERR;
    endcase
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rword;
      d.rresp = rresp;
    end
    d.arready = !d.rvalid;

    // Operator clear; hardware events below override it in the same cycle.
    if (clr) begin
      d.fault = 1'b0;
      d.cmp_fail = 1'b0;
      d.miss = 4'h0;
    end

    // ========================================================================
    // Movement start from the pushbuttons.
    if (q.mv == MV_IDLE && q.sel_valid && !q.fault) begin
      if ((q.btn[BTN_INS] && !q.btn_prev[BTN_INS]) ||
          (q.btn[BTN_CINS] && !q.btn_prev[BTN_CINS])) begin
        d.mv = MV_INS;
        d.mv_cnt = 4'(MOVE_SLOTS - 1);
      end else if (q.btn[BTN_WD] && !q.btn_prev[BTN_WD]) begin
        d.mv = MV_WD;
        d.mv_cnt = 4'(MOVE_SLOTS - 1);
      end
    end

    // ========================================================================
    // Slot timing: medium loop restarts the scan and moves to the next unit.
    d.slot_cnt = (q.slot_cnt == 16'(WORD_CYC_P - 1)) ? 16'h0
                 : q.slot_cnt + 16'h1;
    d.med_cnt = q.med_cnt + 24'h1;
    if (q.med_cnt == 24'(MED_CYC_P - 1)) begin
      d.med_cnt = 24'h0;
      d.scan_idx = '0;
      d.scan_done = 1'b0;
      d.test_step = 4'h0;
      d.test_unit = (q.test_unit == ADDR_W'(ROD_COUNT - 1)) ? '0
                    : q.test_unit + 1'b1;
    end

    unique case (q.phase)
      PH_IDLE: begin
        if (q.slot_cnt == 16'h0) begin
          d.cmd_slot = !q.cmd_slot;
          if (q.cmd_slot) begin
            // No frame while stopped: the valves fall shut on their own.
            if (q.mv != MV_IDLE && !q.fault) begin
              go = 1'b1;
              addr_a = q.sel_a;
              addr_b = q.sel_b;
              unique case (q.mv)
                MV_INS: op = OP_INSERT;
                MV_WD: op = OP_WITHDRAW;
                MV_SET: op = OP_SETTLE;
                MV_IDLE: op = OP_STATUS;
              endcase
              if (q.mv_cnt != 4'h0) begin
                d.mv_cnt = q.mv_cnt - 4'h1;
              end else if (q.mv == MV_SET) begin
                d.mv = MV_IDLE;
              end else if (!(q.mv == MV_INS && q.btn[BTN_CINS]) &&
                           !(q.mv == MV_WD && q.btn[BTN_CWD] &&
                             q.btn[BTN_WD])) begin
                d.mv = MV_SET;
                d.mv_cnt = 4'(SETTLE_SLOTS - 1);
              end
            end
          end else if (!q.scan_done) begin
            go = 1'b1;
            addr_a = q.scan_idx;
            addr_b = q.scan_idx;
            d.scan_idx = q.scan_idx + 1'b1;
            d.scan_done = (q.scan_idx == ADDR_W'(ROD_COUNT - 1));
          end else if (q.test_step != 4'(TEST_STEPS)) begin
            go = 1'b1;
            addr_a = q.test_unit;
            addr_b = q.test_unit;
            op = OP_TEST | {2'b00, q.test_step[1:0]};
            d.test_step = q.test_step + 4'h1;
          end
          if (go) begin
            d.motion_frame = q.cmd_slot;
            d.sh_a = rmc_build_cmd(addr_a, op);
            d.sh_b = rmc_build_cmd(addr_b, op);
            d.word_b = d.sh_b;
            d.bit_cnt = 7'h0;
            d.phase = PH_CMP;
          end
        end
      end
      PH_CMP: begin
        if (q.sh_a[CMD_W-1] != q.sh_b[CMD_W-1]) begin
          d.cmp_fail = 1'b1;
          d.fault = 1'b1;
          d.mv = MV_IDLE;
          d.phase = PH_IDLE;
        end else begin
          d.sh_a = {q.sh_a[CMD_W-2:0], 1'b0};
          d.sh_b = {q.sh_b[CMD_W-2:0], 1'b0};
          d.bit_cnt = q.bit_cnt + 7'h1;
          if (q.bit_cnt == 7'(CMD_W - 1)) begin
            d.sh_b = q.word_b;
            d.bit_cnt = 7'h0;
            d.phase = PH_SEND;
          end
        end
      end
      PH_SEND: begin
        d.cmd_frame = 1'b1;
        d.cmd_bit = q.sh_b[CMD_W-1];
        d.sh_b = {q.sh_b[CMD_W-2:0], 1'b0};
        d.bit_cnt = q.bit_cnt + 7'h1;
        if (q.bit_cnt == 7'(CMD_W - 1)) begin
          d.bit_cnt = 7'h0;
          d.rx_cnt = 6'h0;
          d.phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        d.bit_cnt = q.bit_cnt + 7'h1;
        if (link.rep_frame) begin
          d.rx = {q.rx[REP_W-2:0], link.rep_bit};
          d.rx_cnt = q.rx_cnt + 6'h1;
        end
        if (q.rx_cnt == 6'(REP_W)) begin
          d.last_rep = q.rx;
          d.phase = PH_IDLE;
          // Only motion frames count, so an empty scan address never
          // stops the selected rod.
          if (q.rx[REP_W-1 -: CMD_W] == q.word_b) begin
            if (q.motion_frame) begin
              d.miss = 4'h0;
            end
          end else begin
            miss_ev = q.motion_frame;
          end
        end else if (q.rx_cnt == 6'h0 &&
                     q.bit_cnt == 7'(REPLY_TO_CYC)) begin
          miss_ev = q.motion_frame;
          d.phase = PH_IDLE;
        end
      end
    endcase

    // Single noisy replies are tolerated; a run of them stops the rod.
    if (miss_ev) begin
      if (q.miss != 4'hF) begin
        d.miss = q.miss + 4'h1;
      end
      if (q.miss >= 4'(MISS_LIMIT - 1)) begin
        d.fault = 1'b1;
        d.mv = MV_IDLE;
      end
    end
    d.moving = (d.mv != MV_IDLE);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.cmd_bit = q.cmd_bit;
  assign link.cmd_frame = q.cmd_frame;
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign moving_o = q.moving;
  assign fault_o = q.fault;

endmodule : rmc_sequencer

/* File: sim/rmc_link_properties.sv */
// Protocol checker for the rod command and reply frames.
`timescale 1ns/10ps
module rmc_link_properties #(
  parameter int WORD_CYC_P = 200
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cmd_bit,
  input wire logic cmd_frame,
  input wire logic rep_bit,
  input wire logic rep_frame
);
  // ==========
  // Frame trackers
  logic [4:0] cmd_len_ff;
  logic [4:0] rep_len_ff;
  logic [15:0] gap_ff;
  logic [12:0] cmd_sh_ff;
  logic [20:0] rep_sh_ff;

  // The gap starts saturated, so the first frame after reset is not judged.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_len_ff <= 5'h00;
      rep_len_ff <= 5'h00;
      gap_ff <= 16'hFFFF;
      cmd_sh_ff <= 13'h0;
      rep_sh_ff <= 21'h0;
    end else begin
      cmd_len_ff <= cmd_frame ? cmd_len_ff + 5'h01 : 5'h00;
      rep_len_ff <= rep_frame ? rep_len_ff + 5'h01 : 5'h00;
      if (cmd_frame) begin
        gap_ff <= 16'h0000;
        cmd_sh_ff <= {cmd_sh_ff[11:0], cmd_bit};
      end else if (gap_ff != 16'hFFFF) begin
        gap_ff <= gap_ff + 16'h0001;
      end
      if (rep_frame) begin
        rep_sh_ff <= {rep_sh_ff[19:0], rep_bit};
      end
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_cmd_open;
    !cmd_frame ##1 cmd_frame;
  endsequence
  sequence s_cmd_close;
    cmd_frame ##1 !cmd_frame;
  endsequence
  sequence s_rep_open;
    !rep_frame ##1 rep_frame;
  endsequence
  sequence s_rep_close;
    rep_frame ##1 !rep_frame;
  endsequence

  chk_cmd_length: assert property (s_cmd_close |-> cmd_len_ff == 5'h0D)
    else $error("command frame length wrong");
  chk_cmd_bound: assert property (cmd_frame |-> cmd_len_ff < 5'h0D)
    else $error("command frame too long");
  chk_rep_length: assert property (s_rep_close |-> rep_len_ff == 5'h15)
    else $error("reply frame length wrong");
  chk_frame_gap: assert property (s_cmd_open |-> gap_ff >= WORD_CYC_P - 16)
    else $error("frames closer than one slot");
  // A reply begins two cycles after the first idle cycle of its command.
  chk_reply_delay: assert property (
    s_rep_open |-> !$past(cmd_frame, 2) && $past(cmd_frame, 3))
    else $error("reply not tied to a command");
  chk_reply_quiet: assert property (!rep_frame |-> !rep_bit)
    else $error("reply line active outside a reply");
  chk_no_overlap: assert property (rep_frame |-> !cmd_frame)
    else $error("command sent during a reply");
  chk_reply_addr: assert property (
    s_rep_close |-> rep_sh_ff[20:12] == cmd_sh_ff[12:4])
    else $error("reply address differs from command");
  chk_reply_op: assert property (
    s_rep_close |-> rep_sh_ff[11:8] == cmd_sh_ff[3:0])
    else $error("reply operation differs from command");
endmodule : rmc_link_properties

/* File: sim/rod_motion_command_sequencer_test.sv */
// Self-checking bench of the sequencer and rod unit pair.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end
module rod_motion_command_sequencer_test
  import rmc_pkg::*;
;
  localparam int WORD_P = 200;
  localparam logic [8:0] UNIT_ADDR = 9'h05A;
  localparam logic [8:0] LOST_ADDR = 9'h05B;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] btn = 4'h0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, moving, fault;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [3:0] valves;
  int err_total = 0;
  int checks_done = 0;

  always #10 clk_i = ~clk_i;

  rmc_link_if rmc_link_if_inst ();
  rmc_sequencer #(.WORD_CYC_P(WORD_P), .MED_CYC_P(3000)) rmc_sequencer_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .btn_i(btn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .moving_o(moving), .fault_o(fault), .link(rmc_link_if_inst.seq));
  rmc_rod_unit #(.HOLD_CYC_P(600)) rmc_rod_unit_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .unit_addr_i(UNIT_ADDR),
    .accum_ok_i(1'b1), .test_sw_i(3'h5), .valves_o(valves),
    .link(rmc_link_if_inst.unit));
  rmc_link_properties #(.WORD_CYC_P(WORD_P)) rmc_link_properties_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .cmd_bit(rmc_link_if_inst.cmd_bit),
    .cmd_frame(rmc_link_if_inst.cmd_frame),
    .rep_bit(rmc_link_if_inst.rep_bit),
    .rep_frame(rmc_link_if_inst.rep_frame));

  // ==========
  // Bus and panel tasks
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic done;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    logic done;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  // The button is held well past the input synchroniser's settling time.
  task automatic press(input int b, input int n);
    @(posedge clk_i);
    btn[b] <= 1'b1;
    repeat (n) @(posedge clk_i);
    btn[b] <= 1'b0;
  endtask : press

  task automatic wait_vlv(input logic [3:0] p);
    while (valves !== p) @(posedge clk_i);
  endtask : wait_vlv

  // ==========
  // Scenarios
  task automatic t_after_reset();
    `CHK(valves, VLV_CLOSED)
    `CHK(moving, 1'b0)
    axi_rd(REG_STATUS);
    `CHK(rd[11:0], 12'h000)
    axi_rd(4'h2);
    `CHK(rs, RESP_SLVERR)
  endtask : t_after_reset

  task automatic t_insert_cycle();
    axi_wr(REG_SELECT, {22'h0, 1'b1, UNIT_ADDR});
    `CHK(rs, RESP_OKAY)
    press(BTN_INS, 10);
    wait_vlv(VLV_INSERT);
    `CHK(moving, 1'b1)
    axi_wr(REG_SELECT, {22'h0, 1'b1, LOST_ADDR});
    axi_wr(REG_SELECT, 32'h0);
    axi_rd(REG_SELECT);
    `CHK(rd[9:0], {1'b1, UNIT_ADDR})
    axi_rd(REG_STATUS);
    `CHK(rd[5:2], 4'h7)
    wait_vlv(VLV_SETTLE);
    `CHK(valves, VLV_SETTLE)
    wait_vlv(VLV_CLOSED);
    axi_rd(REG_REPLY);
    `CHK(rd[20:12], UNIT_ADDR)
    `CHK(rd[3:0], 4'hD)
    axi_rd(REG_STATUS);
    `CHK(rd[11:0], 12'h008)
  endtask : t_insert_cycle

  task automatic t_withdraw_cycle();
    press(BTN_WD, 10);
    wait_vlv(VLV_WITHDRAW);
    `CHK(valves, VLV_WITHDRAW)
    wait_vlv(VLV_SETTLE);
    `CHK(valves, VLV_SETTLE)
    wait_vlv(VLV_CLOSED);
    `CHK(moving, 1'b0)
    axi_wr(REG_SELECT, 32'h0);
    axi_rd(REG_STATUS);
    `CHK(rd[3], 1'b0)
  endtask : t_withdraw_cycle

  task automatic t_cont_insert();
    axi_wr(REG_SELECT, {22'h0, 1'b1, UNIT_ADDR});
    press(BTN_CINS, 3000);
    `CHK(valves, VLV_INSERT)
    wait_vlv(VLV_SETTLE);
    `CHK(valves, VLV_SETTLE)
    wait_vlv(VLV_CLOSED);
  endtask : t_cont_insert

  task automatic t_cont_withdraw();
    @(posedge clk_i);
    btn <= 4'hA;
    repeat (4000) @(posedge clk_i);
    `CHK(valves, VLV_WITHDRAW)
    btn <= 4'h0;
    wait_vlv(VLV_SETTLE);
    `CHK(moving, 1'b1)
    wait_vlv(VLV_CLOSED);
  endtask : t_cont_withdraw

  // No unit answers this address, so every command slot counts a miss.
  task automatic t_miss_fault();
    axi_wr(REG_SELECT, {22'h0, 1'b1, LOST_ADDR});
    press(BTN_INS, 10);
    while (fault !== 1'b1) @(posedge clk_i);
    `CHK(valves, VLV_CLOSED)
    axi_rd(REG_STATUS);
    `CHK({rd[2], rd[0]}, 2'b01)
    axi_wr(REG_SELECT, {22'h0, 1'b1, UNIT_ADDR});
    press(BTN_INS, 10);
    repeat (2000) @(posedge clk_i);
    `CHK(valves, VLV_CLOSED)
    `CHK(fault, 1'b1)
    axi_wr(REG_CONTROL, 32'h1);
    axi_rd(REG_STATUS);
    `CHK({rd[11:8], rd[0]}, 5'h00)
  endtask : t_miss_fault

  // ==========
  // Run control
  task automatic results();
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_after_reset();
    t_insert_cycle();
    t_withdraw_cycle();
    t_cont_insert();
    t_cont_withdraw();
    t_miss_fault();
    results();
  end
endmodule : rod_motion_command_sequencer_test
